//--- flash_host_pkg.sv
// Purpose: constants shared by the flash host controller and its bus cycle engine
// Assumes: 250 MHz clock, 4 ns period
// Notes: times are kept in their printed units, cycle counts derived from them
package flash_host_pkg;
  localparam int CLK_PERIOD_PS = 4000;
  // protect / unprotect pulse lengths
  localparam int PROTECT_PULSE_US = 150;
  localparam int UNPROTECT_PULSE_MS = 15;
  localparam int PROTECT_PULSE_CYC = (PROTECT_PULSE_US * 1000000) / CLK_PERIOD_PS;
  localparam int UNPROTECT_PULSE_CYC = (UNPROTECT_PULSE_MS * 1000000) / CLK_PERIOD_PS * 1000;
  // bus cycle timing (least times, rounded up)
  localparam int READ_WRITE_GAP_NS = 20;
  localparam int GAP_CYC = (READ_WRITE_GAP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int WRITE_PULSE_NS = 35;
  localparam int WRITE_PULSE_CYC = (WRITE_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int READ_ACCESS_NS = 90;
  localparam int READ_ACCESS_CYC = (READ_ACCESS_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // protect address encoding bit positions
  localparam int PROT_DIR_POS = 6;
  localparam int PROT_SEL1_POS = 1;
  localparam int PROT_SEL0_POS = 0;
  // status bit positions
  localparam int POLL_BIT_POS = 7;
  localparam int ACT_TOGGLE_POS = 6;
  localparam int SUSP_TOGGLE_POS = 2;
  // command codes of the operation port
  typedef enum logic [2:0] {
    OP_PROGRAM = 3'b000,
    OP_ERASE = 3'b001,
    OP_PROTECT = 3'b010,
    OP_UNPROTECT = 3'b011,
    OP_READ = 3'b100
  } op_type;
  // unlock sequence values
  localparam logic [15:0] UNLOCK_ADDR1 = 16'h0555;
  localparam logic [15:0] UNLOCK_ADDR2 = 16'h02AA;
  localparam logic [15:0] UNLOCK_DATA1 = 16'h00AA;
  localparam logic [15:0] UNLOCK_DATA2 = 16'h0055;
  localparam logic [15:0] CMD_PROGRAM = 16'h00A0;
  localparam logic [15:0] CMD_ERASE_SETUP = 16'h0080;
  localparam logic [15:0] CMD_SECTOR_ERASE = 16'h0030;
  localparam logic [15:0] CMD_UNLOCK_BYPASS_PROG = 16'h00A0;
endpackage

//--- flash_bus_cycle.sv
// Purpose: one asynchronous flash bus cycle, read or write, with strobe timing
// Assumes: pin inputs synchronous to clk
// Notes: a gap of idle time always follows a cycle, so read/write turnaround is safe
`timescale 1ns/100ps
`default_nettype none
module flash_bus_cycle
  import flash_host_pkg::*;
#(
  parameter int AW = 20,
  parameter int DW = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // request side
  input wire logic req,
  input wire logic req_write,
  input wire logic [AW-1:0] req_addr,
  input wire logic [DW-1:0] req_data,
  output logic ack,
  output logic [DW-1:0] rd_data,
  // flash pins
  output logic [AW-1:0] addr,
  input wire logic [DW-1:0] dq_in,
  output logic [DW-1:0] dq_out,
  output logic dq_oe,
  output logic ce_n,
  output logic oe_n,
  output logic we_n
);
  typedef enum logic [1:0] {
    CY_IDLE = 2'b00,
    CY_STROBE = 2'b01,
    CY_GAP = 2'b10
  } cy_type;
  cy_type st_q, st_d;
  logic [7:0] cnt_q;
  logic wr_q;
  logic [DW-1:0] rd_q;
  logic [AW-1:0] addr_q;
  logic [DW-1:0] dout_q;
  wire logic strobe_done = (st_q == CY_STROBE) &&
    (cnt_q == (wr_q ? 8'(WRITE_PULSE_CYC - 1) : 8'(READ_ACCESS_CYC - 1)));
  wire logic gap_done = (st_q == CY_GAP) && (cnt_q == 8'(GAP_CYC - 1));
  // next state of the cycle engine
  always_comb begin
    st_d = st_q;
    case (st_q)
      CY_IDLE: if (req) st_d = CY_STROBE;
      CY_STROBE: if (strobe_done) st_d = CY_GAP;
      CY_GAP: if (gap_done) st_d = CY_IDLE;
      default: st_d = CY_IDLE;
    endcase
  end
  // each read pulses ce/oe anew, which is what makes the toggle bits advance
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= CY_IDLE;
      cnt_q <= 8'h00;
      wr_q <= 1'b0;
      addr_q <= '0;
      dout_q <= '0;
      rd_q <= '0;
    end else begin
      st_q <= st_d;
      cnt_q <= (st_d != st_q) ? 8'h00 : cnt_q + 8'h01;
      if (st_q == CY_IDLE && req) begin
        wr_q <= req_write;
        addr_q <= req_addr;
        dout_q <= req_data;
      end
      if (strobe_done && !wr_q) rd_q <= dq_in;
    end
  end
  // strobes low only during the strobe phase; gap keeps 20 ns between cycles
  assign ce_n = (st_q != CY_STROBE); // RULE_02
  assign oe_n = !((st_q == CY_STROBE) && !wr_q);
  assign we_n = !((st_q == CY_STROBE) && wr_q);
  assign dq_oe = (st_q == CY_STROBE) && wr_q;
  assign dq_out = dout_q;
  assign addr = addr_q;
  assign rd_data = rd_q;
  assign ack = gap_done; // RULE_12
endmodule
`default_nettype wire

//--- flash_host_ctrl.sv
// Purpose: host controller issuing program, erase, protect and read to a parallel NOR flash
// Assumes: one clock at 250 MHz, flash pins sampled synchronously
// Notes: program and erase completion found by status polling; ready_busy_n input left unused
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// RULE_01 - device toggles suspend bit only inside an erase-suspended sector
// RULE_02 - each status read is a fresh chip/output enable pulse
// RULE_03 - protect: dir bit low, select bit one high, bit zero low, sector address
// RULE_04 - unprotect: dir bit high, select bit one high, bit zero low
// RULE_05 - hold protect pulse 150 us before checking
// RULE_06 - hold unprotect pulse 15 ms before verifying
// RULE_07 - device returns inverted polling bit while programming
// RULE_08 - device flips activity toggle bit on every status read
// RULE_09 - device returns true data after the algorithm completes
// RULE_10 - program takes about 7 us
// RULE_11 - sector erase takes about 0.7 s
// RULE_12 - keep 20 ns between read and write cycles
// RULE_13 - erase preprograms region to zero first
// RULE_14 - program command is two or four write cycles
// RULE_15 - poll until polling bit matches data or toggle bit stops
// RULE_16 - device holds ready_busy_n low while busy
module flash_host_ctrl
  import flash_host_pkg::*;
#(
  parameter int AW = 20,
  parameter int DW = 16,
  parameter int PROT_CYC = PROTECT_PULSE_CYC,
  parameter int UNPROT_CYC = UNPROTECT_PULSE_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // user command port
  input wire logic cmd_valid,
  input wire flash_host_pkg::op_type cmd_op,
  input wire logic [AW-1:0] cmd_addr,
  input wire logic [DW-1:0] cmd_data,
  input wire logic cmd_bypass,
  output logic cmd_ready,
  output logic done,
  output logic fail,
  output logic [DW-1:0] result_data,
  // flash pins
  output logic [AW-1:0] flash_addr,
  input wire logic [DW-1:0] flash_dq_in,
  output logic [DW-1:0] flash_dq_out,
  output logic flash_dq_oe,
  output logic flash_ce_n,
  output logic flash_oe_n,
  output logic flash_we_n,
  output logic flash_reset_n,
  input wire logic ready_busy_n
);
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_SEQ = 3'b001,
    S_POLL = 3'b010,
    S_PULSE = 3'b011,
    S_VERIFY = 3'b100,
    S_READ = 3'b101
  } st_type;
  st_type st_q, st_d;
  op_type op_q;
  logic [AW-1:0] addr_q;
  logic [DW-1:0] data_q;
  logic [2:0] step_q;
  logic bypass_q;
  logic [31:0] wait_q;
  logic have_prev_q;
  logic [DW-1:0] prev_q;
  logic done_q, fail_q;
  logic [DW-1:0] result_q;
  logic bus_req, bus_write, bus_ack;
  logic [AW-1:0] bus_addr;
  logic [DW-1:0] bus_data, bus_rd;
  // command write sequence: 4 cycles program, 2 cycles in bypass, 6 for erase
  wire logic [2:0] seq_len = (op_q == OP_ERASE) ? 3'd6 : (bypass_q ? 3'd2 : 3'd4); // RULE_14
  wire logic [AW-1:0] seq_addr =
    (op_q == OP_PROGRAM && step_q == seq_len - 3'd1) ? addr_q :
    (op_q == OP_ERASE && step_q == 3'd5) ? addr_q :
    (op_q == OP_PROGRAM && bypass_q) ? '0 :
    (step_q == 3'd1 || step_q == 3'd4) ? AW'(UNLOCK_ADDR2) : AW'(UNLOCK_ADDR1);
  wire logic [DW-1:0] seq_data =
    (op_q == OP_PROGRAM && step_q == seq_len - 3'd1) ? data_q :
    (op_q == OP_PROGRAM && bypass_q) ? DW'(CMD_UNLOCK_BYPASS_PROG) :
    (op_q == OP_ERASE && step_q == 3'd5) ? DW'(CMD_SECTOR_ERASE) :
    (op_q == OP_ERASE && step_q == 3'd2) ? DW'(CMD_ERASE_SETUP) :
    (step_q == 3'd1 || step_q == 3'd4) ? DW'(UNLOCK_DATA2) :
    (step_q == 3'd2) ? DW'(CMD_PROGRAM) : DW'(UNLOCK_DATA1);
  // protect address: sector address with the three select bits forced
  wire logic [AW-1:0] prot_addr = (addr_q
    & ~(AW'(1) << PROT_DIR_POS) & ~(AW'(1) << PROT_SEL0_POS))
    | (AW'(1) << PROT_SEL1_POS)
    | (AW'(op_q == OP_UNPROTECT) << PROT_DIR_POS); // RULE_03 RULE_04
  // status polling is finished once a program's polling bit shows the true data, or
  // the activity bit no longer flips between two reads
  wire logic poll_match = (op_q == OP_PROGRAM) &&
    (bus_rd[POLL_BIT_POS] == data_q[POLL_BIT_POS]); // RULE_07 RULE_15
  wire logic toggle_still = have_prev_q &&
    (bus_rd[ACT_TOGGLE_POS] == prev_q[ACT_TOGGLE_POS]); // RULE_08 RULE_15
  wire logic poll_end = bus_ack && (poll_match || toggle_still);
  wire logic pulse_len_done = (op_q == OP_PROTECT) ? (wait_q >= 32'(PROT_CYC - 1))
    : (wait_q >= 32'(UNPROT_CYC - 1)); // RULE_05 RULE_06
  // bus request selection
  assign bus_req = (st_q == S_SEQ) || (st_q == S_POLL) || (st_q == S_VERIFY) ||
    (st_q == S_READ);
  assign bus_write = (st_q == S_SEQ);
  assign bus_addr = (st_q == S_SEQ) ? seq_addr :
    (st_q == S_VERIFY) ? prot_addr : addr_q;
  assign bus_data = seq_data;
  // controller state
  always_comb begin
    st_d = st_q;
    case (st_q)
      S_IDLE: if (cmd_valid) begin
        case (cmd_op)
          OP_PROGRAM, OP_ERASE: st_d = S_SEQ;
          OP_PROTECT, OP_UNPROTECT: st_d = S_PULSE;
          default: st_d = S_READ;
        endcase
      end
      S_SEQ: if (bus_ack && step_q == seq_len - 3'd1) st_d = S_POLL;
      // erase also covers the internal zero preprogram; poll the whole span
      S_POLL: if (poll_end) st_d = S_IDLE; // RULE_10 RULE_11 RULE_13
      S_PULSE: if (pulse_len_done) st_d = S_VERIFY;
      S_VERIFY: if (bus_ack) st_d = S_IDLE;
      S_READ: if (bus_ack) st_d = S_IDLE;
      default: st_d = S_IDLE;
    endcase
  end
  // a command is taken only in idle; later offers are ignored until done
  wire logic cmd_take = (st_q == S_IDLE) && cmd_valid;
  // state register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= S_IDLE;
    end else begin
      st_q <= st_d;
    end
  end
  // command capture; the fields stay put for the whole operation
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      op_q <= OP_READ;
      addr_q <= '0;
      data_q <= '0;
      bypass_q <= 1'b0;
    end else if (cmd_take) begin
      op_q <= cmd_op;
      addr_q <= cmd_addr;
      data_q <= cmd_data;
      bypass_q <= cmd_bypass;
    end
  end
  // write step of the command sequence, advanced per finished bus cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      step_q <= 3'd0;
    end else if (cmd_take) begin
      step_q <= 3'd0;
    end else if (st_q == S_SEQ && bus_ack) begin
      step_q <= step_q + 3'd1;
    end
  end
  // pulse length counter; cleared outside the pulse so each pulse starts fresh
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wait_q <= 32'h0000_0000;
    end else begin
      wait_q <= (st_q == S_PULSE) ? wait_q + 32'h0000_0001 : 32'h0000_0000;
    end
  end
  // previous status word; the first poll read has nothing to compare against
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      have_prev_q <= 1'b0;
      prev_q <= '0;
    end else if (cmd_take) begin
      have_prev_q <= 1'b0;
    end else if (st_q == S_POLL && bus_ack) begin
      prev_q <= bus_rd;
      have_prev_q <= 1'b1;
    end
  end
  // completion pulses; done and fail last a single cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      done_q <= 1'b0;
      fail_q <= 1'b0;
    end else begin
      done_q <= ((st_q == S_POLL) && poll_end) ||
        ((st_q == S_VERIFY || st_q == S_READ) && bus_ack);
      fail_q <= (st_q == S_VERIFY) && bus_ack &&
        (bus_rd[0] != (op_q == OP_PROTECT));
    end
  end
  // result word; a protect verify reads back bit zero as the protect state
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      result_q <= '0;
    end else if (bus_ack && st_q != S_SEQ) begin
      result_q <= bus_rd; // RULE_09
    end
  end
  assign cmd_ready = (st_q == S_IDLE);
  assign done = done_q;
  assign fail = fail_q;
  assign result_data = result_q;
  assign flash_reset_n = 1'b1;
  // bus cycle engine
  flash_bus_cycle #(.AW(AW), .DW(DW)) u_cycle (
    .clk(clk),
    .rstn(rstn),
    .req(bus_req),
    .req_write(bus_write),
    .req_addr(bus_addr),
    .req_data(bus_data),
    .ack(bus_ack),
    .rd_data(bus_rd),
    .addr(flash_addr),
    .dq_in(flash_dq_in),
    .dq_out(flash_dq_out),
    .dq_oe(flash_dq_oe),
    .ce_n(flash_ce_n),
    .oe_n(flash_oe_n),
    .we_n(flash_we_n)
  );
endmodule
`default_nettype wire

//--- flash_dev_model.sv
// Purpose: behavioural flash device on the far side of the host controller
// Assumes: pins sampled on clk, one embedded operation at a time
// Notes: busy times are parameters; erase suspend is not modelled
`timescale 1ns/100ps
`default_nettype none
module flash_dev_model #(
  parameter int PROG_CYC = 1750,
  parameter int ERASE_CYC = 3000
) (
  // clock
  input wire logic clk,
  // flash pins
  input wire logic [19:0] addr,
  input wire logic [15:0] din,
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  output logic [15:0] dout,
  output logic busy_n
);
  logic [15:0] mem [logic [19:0]];
  logic [15:0] last_q = 16'h0000;
  logic [15:0] held_q = 16'h0000;
  logic [15:0] pv_q = 16'h0000;
  logic [15:0] val;
  logic tog_q = 1'b0;
  logic rd_q = 1'b0;
  logic wr_q = 1'b0;
  int busy_q = 0;
  wire rd = !ce_n && !oe_n;
  wire wr = !ce_n && !we_n;
  // status while busy, else array or protect state; released bus shows inverse
  always_comb begin
    val = mem.exists(addr) ? mem[addr] : 16'hFFFF;
    if (addr[1:0] == 2'b10) val = {15'h0, !addr[6]};
    if (busy_q > 0) val = {8'h00, !pv_q[7], tog_q, 6'h00};
    dout = rd ? val : ~held_q;
    busy_n = (busy_q == 0);
  end
  // commands decoded at the start of each write pulse
  always @(posedge clk) begin
    rd_q <= rd;
    wr_q <= wr;
    if (rd) held_q <= val;
    if (busy_q > 0) busy_q <= busy_q - 1;
    if (rd && !rd_q) tog_q <= !tog_q;
    if (wr && !wr_q) begin
      last_q <= din;
      if (last_q == 16'h00A0) begin
        mem[addr] = din;
        pv_q <= din;
        busy_q <= PROG_CYC;
      end else if (din == 16'h0030 && last_q == 16'h0055) begin
        // zero-fill step folded into the erase busy time
        // entries are rewritten, not deleted, so the walk over the array stays safe
        foreach (mem[k]) if (k[19:15] == addr[19:15]) mem[k] = 16'hFFFF;
        pv_q <= 16'hFFFF;
        busy_q <= ERASE_CYC;
      end
    end
  end
endmodule
`default_nettype wire

//--- flash_host_ctrl_properties.sv
// Purpose: pin timing checks of the flash host controller
// Assumes: one clock domain, async active-low reset
// Notes: gap and pulse figures follow the bus cycle walk
`timescale 1ns/100ps
`default_nettype none
module flash_host_ctrl_checker #(
  parameter int PROT_CYC = 50,
  parameter int UNPROT_CYC = 50
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // observed ports
  input wire logic cmd_ready,
  input wire logic done,
  input wire logic fail,
  input wire logic flash_dq_oe,
  input wire logic flash_ce_n,
  input wire logic flash_oe_n,
  input wire logic flash_we_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  a_no_overlap: assert property (!(!flash_we_n && !flash_oe_n))
    else $error("read and write strobes overlap");
  a_wr_rd_gap: assert property ($rose(flash_we_n) |-> flash_oe_n [*5])
    else $error("read too soon after write");
  a_rd_wr_gap: assert property ($rose(flash_oe_n) |-> flash_we_n [*5])
    else $error("write too soon after read");
  a_read_pulse: assert property ($fell(flash_oe_n) |-> !flash_ce_n [*8])
    else $error("status read pulse too short");
  a_write_drive: assert property (!flash_we_n |-> flash_dq_oe && !flash_ce_n)
    else $error("write cycle without data drive");
  a_write_width: assert property ($fell(flash_we_n) |-> !flash_we_n [*8])
    else $error("write pulse too short");
  a_read_release: assert property (!flash_oe_n |-> !flash_dq_oe)
    else $error("data driven during read");
  a_done_idle: assert property (done |=> !done && cmd_ready)
    else $error("done not a single pulse into idle");
  a_fail_done: assert property (fail |-> done)
    else $error("fail without done");
endmodule
bind flash_host_ctrl flash_host_ctrl_checker #(.PROT_CYC(PROT_CYC), .UNPROT_CYC(UNPROT_CYC))
  u_chk (.clk, .rstn, .cmd_ready, .done, .fail, .flash_dq_oe, .flash_ce_n, .flash_oe_n,
  .flash_we_n);
`default_nettype wire

//--- testbench.sv
// Purpose: self-checking bench of the flash host controller against a device model
// Assumes: protect pulse counts shortened to 50 cycles
// Notes: results are queued by the driver and compared when done pulses
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import flash_host_pkg::*;
  localparam int PC = 50;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic cmd_valid = 1'b0;
  op_type cmd_op = OP_READ;
  logic [19:0] cmd_addr = 20'h00000;
  logic [15:0] cmd_data = 16'h0000;
  logic cmd_bypass = 1'b0;
  logic cmd_ready, done, fail, flash_dq_oe, flash_ce_n, flash_oe_n, flash_we_n, ready_busy_n;
  logic [15:0] result_data, flash_dq_out, flash_dq_in;
  logic [19:0] flash_addr, a;
  logic [15:0] d;
  logic [16:0] expq [$];
  int bad_count = 0;
  int compares = 0;
  int cycles = 0;
  int seed = 95201;
  int lat = 0;
  always #2 clk = !clk;
  flash_host_ctrl #(.PROT_CYC(PC), .UNPROT_CYC(PC)) i_dut (.clk, .rstn, .cmd_valid, .cmd_op,
    .cmd_addr, .cmd_data, .cmd_bypass, .cmd_ready, .done, .fail, .result_data, .flash_addr,
    .flash_dq_in, .flash_dq_out, .flash_dq_oe, .flash_ce_n, .flash_oe_n, .flash_we_n,
    .flash_reset_n(), .ready_busy_n);
  flash_dev_model i_dev (.clk, .addr(flash_addr), .din(flash_dq_out), .ce_n(flash_ce_n),
    .oe_n(flash_oe_n), .we_n(flash_we_n), .dout(flash_dq_in), .busy_n(ready_busy_n));
  task automatic check(logic [16:0] seen, logic [16:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // offer one command, note its result, wait for done with a bound
  task automatic run(op_type op, logic [19:0] ad, logic [15:0] dt, logic byp, logic [16:0] ex);
    expq.push_back(ex);
    @(negedge clk);
    cmd_op = op;
    cmd_addr = ad;
    cmd_data = dt;
    cmd_bypass = byp;
    cmd_valid = 1'b1;
    while (cmd_ready !== 1'b1) @(negedge clk);
    @(negedge clk);
    cmd_valid = 1'b0;
    lat = 0;
    while (done !== 1'b1 && lat < 20000) begin
      @(negedge clk);
      lat++;
    end
    // a command that never finishes is a failure of its own
    if (done !== 1'b1) begin
      bad_count++;
      stop_test();
    end
  endtask
  // result watcher at the falling edge, where done and result have settled
  always @(negedge clk) begin
    if (done === 1'b1) begin
      check({fail, result_data}, expq.size() ? expq.pop_front() : 17'h1FFFF);
      check({16'h0000, ready_busy_n}, 17'h00001);
    end
  end
  // hang guard, well above the expected run length
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      bad_count++;
      stop_test();
    end
  end
  initial begin
    repeat (20) @(posedge clk);
    @(negedge clk);
    rstn = 1'b1;
    for (int i = 0; i < 6; i++) begin
      a = 20'($random(seed));
      a[1:0] = 2'b00;
      d = 16'($random(seed));
      run(OP_PROGRAM, a, d, i[0], {1'b0, d});
      run(OP_READ, a, 16'h0000, 1'b0, {1'b0, d});
    end
    run(OP_ERASE, a, 16'h0000, 1'b0, {1'b0, 16'hFFFF});
    run(OP_READ, a, 16'h0000, 1'b0, {1'b0, 16'hFFFF});
    run(OP_PROTECT, 20'h08000, 16'h0000, 1'b0, {1'b0, 16'h0001});
    check({16'h0000, lat >= PC}, 17'h00001);
    run(OP_UNPROTECT, 20'h08000, 16'h0000, 1'b0, {1'b0, 16'h0000});
    check({16'h0000, lat >= PC}, 17'h00001);
    repeat (10) @(posedge clk);
    stop_test();
  end
endmodule
`default_nettype wire
